// ==== design/rxc_defines.vh ====
// constants for the receive client word stream block
`ifndef RXC_DEFINES_VH
`define RXC_DEFINES_VH

// ------------------------------------------------------------
// bus geometry
// ------------------------------------------------------------
`define RXC_WORDS_100G     4
`define RXC_WORDS_40G      2
`define RXC_WORD_BYTES     8
`define RXC_EMPTY_BITS     3
`define RXC_FIFO_DEPTH     4
`define RXC_FIFO_AW        2

// ------------------------------------------------------------
// client bus rates in kHz (390.625 MHz and 312.5 MHz)
// ------------------------------------------------------------
`define RXC_FREQ_100G_KHZ  32'h0005_f5e1
`define RXC_FREQ_40G_KHZ   32'h0004_c4b4

// ------------------------------------------------------------
// control characters on the lane stream
// ------------------------------------------------------------
`define RXC_CH_START       8'hfb
`define RXC_CH_TERM        8'hfd
`define RXC_CH_IDLE        8'h07
`define RXC_CTRL_ALL       8'hff

// ------------------------------------------------------------
// offset from terminate back to the last kept byte
// ------------------------------------------------------------
`define RXC_END_OFS_KEEP   4'h1
`define RXC_END_OFS_STRIP  4'h5
`define RXC_LAST_LANE      4'h7

`endif

// ==== design/rxc_lane.v ====
// per-word lane scanner: finds start and terminate characters
`timescale 1ns/1ps
`include "rxc_defines.vh"

module rxc_lane (
    // one 8-byte word and its control flags
    input  wire [63:0] word_d,
    input  wire [7:0]  word_c,
    // scan results
    output wire        is_start,
    output reg         has_term,
    output reg  [2:0]  term_lane
);

    integer k;

    // start character sits in lane 0 of the preamble word
    assign is_start = word_c[0] && (word_d[7:0] == `RXC_CH_START);

    // lowest lane holding a terminate wins
    always @* begin
        has_term  = 1'b0;
        term_lane = 3'h0;
        for (k = 7; k >= 0; k = k - 1) begin
            if (word_c[k] && (word_d[k*8 +: 8] == `RXC_CH_TERM)) begin
                has_term  = 1'b1;
                term_lane = k[2:0];
            end
        end
    end

endmodule

// ==== design/rxc_fifo.v ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`include "rxc_defines.vh"

module rxc_fifo #(
    parameter WIDTH = 288,
    parameter DEPTH = `RXC_FIFO_DEPTH,
    parameter AW    = `RXC_FIFO_AW
) (
    // clock and reset
    input  wire             clock,
    input  wire             resetn,
    // fill side
    input  wire             wr_valid,
    output wire             wr_ready,
    input  wire [WIDTH-1:0] wr_data,
    // drain side
    output wire             rd_valid,
    input  wire             rd_ready,
    output wire [WIDTH-1:0] rd_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_r;
    reg [AW:0]      rd_ptr_r;
    wire            full;
    wire            empty;
    wire            do_wr;
    wire            do_rd;

    // extra pointer bit tells full from empty
    assign empty    = (wr_ptr_r == rd_ptr_r);
    assign full     = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                      (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign wr_ready = !full;
    assign rd_valid = !empty;
    assign do_wr    = wr_valid && !full;
    assign do_rd    = rd_ready && !empty;
    assign rd_data  = mem[rd_ptr_r[AW-1:0]];

    // storage write
    always @(posedge clock) begin
        if (do_wr) begin
            mem[wr_ptr_r[AW-1:0]] <= wr_data;
        end
    end

    // pointers
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= {(AW+1){1'b0}};
            rd_ptr_r <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

endmodule

// ==== design/rxc_stream.v ====
// receive client word stream: marks start, end and empty bytes
`timescale 1ns/1ps
`include "rxc_defines.vh"

module rxc_stream #(
    parameter W = `RXC_WORDS_100G,
    parameter FIFO_DEPTH = `RXC_FIFO_DEPTH,
    parameter FIFO_AW    = `RXC_FIFO_AW
) (
    // clock and reset
    input  wire           clock,
    input  wire           resetn,
    // mode pins
    input  wire           preamble_pass,
    input  wire           crc_strip,
    input  wire           drain_hold,
    // lane stream from the decoder
    input  wire           in_valid,
    output wire           in_ready,
    input  wire [W*64-1:0] in_d,
    input  wire [W*8-1:0]  in_c,
    // client word bus
    output reg  [W*64-1:0] dout_d,
    output reg  [W*8-1:0]  dout_c,
    output reg  [W-1:0]    dout_sop,
    output reg  [W-1:0]    dout_eop,
    output reg  [W*3-1:0]  dout_eop_empty,
    output reg             dout_valid
);

    // --------------------------------------------------------
    // widths
    // --------------------------------------------------------
    localparam DW = W * 64;
    localparam CW = W * 8;
    localparam EW = W * 3;
    localparam FW = DW + CW;

    // --------------------------------------------------------
    // mode pin synchronisers
    // --------------------------------------------------------
    reg  pre_pass_m_r;
    reg  pre_pass_s_r;
    reg  crc_strip_m_r;
    reg  crc_strip_s_r;

    // two flops each on preamble_pass and crc_strip before any logic reads them; drain_hold is read directly
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pre_pass_m_r  <= 1'b0;
            pre_pass_s_r  <= 1'b0;
            crc_strip_m_r <= 1'b0;
            crc_strip_s_r <= 1'b0;
        end else begin
            pre_pass_m_r  <= preamble_pass;
            pre_pass_s_r  <= pre_pass_m_r;
            crc_strip_m_r <= crc_strip;
            crc_strip_s_r <= crc_strip_m_r;
        end
    end

    // --------------------------------------------------------
    // input fifo
    // --------------------------------------------------------
    wire          hd_valid;
    wire          hd_ready;
    wire [FW-1:0] hd_data;
    wire [DW-1:0] hd_d;
    wire [CW-1:0] hd_c;
    wire          adv;

    // drain only while not held; hold makes the fifo fill up
    assign hd_ready = !drain_hold;
    assign adv      = hd_valid && hd_ready;
    assign hd_d     = hd_data[DW-1:0];
    assign hd_c     = hd_data[FW-1:DW];

    rxc_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clock    (clock),
        .resetn   (resetn),
        .wr_valid (in_valid),
        .wr_ready (in_ready),
        .wr_data  ({in_c, in_d}),
        .rd_valid (hd_valid),
        .rd_ready (hd_ready),
        .rd_data  (hd_data)
    );

    // --------------------------------------------------------
    // lane scan of the fifo head
    // --------------------------------------------------------
    wire [W-1:0]  hd_start;
    wire [W-1:0]  hd_term;
    wire [EW-1:0] hd_lane;

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_scan
            rxc_lane u_lane (
                .word_d    (hd_d[g*64 +: 64]),
                .word_c    (hd_c[g*8 +: 8]),
                .is_start  (hd_start[g]),
                .has_term  (hd_term[g]),
                .term_lane (hd_lane[g*3 +: 3])
            );
        end
    endgenerate

    // --------------------------------------------------------
    // look-ahead stage: one cycle of words held back
    // --------------------------------------------------------
    reg  [DW-1:0] s1_d_r;
    reg  [CW-1:0] s1_c_r;
    reg  [W-1:0]  s1_start_r;
    reg  [W-1:0]  s1_term_r;
    reg  [EW-1:0] s1_lane_r;
    reg           start_last_r;

    // the end of a frame may only show in the next word, so the
    // stage waits for the following fifo word before it goes out
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_d_r       <= {W{{`RXC_WORD_BYTES{`RXC_CH_IDLE}}}};
            s1_c_r       <= {W{`RXC_CTRL_ALL}};
            s1_start_r   <= {W{1'b0}};
            s1_term_r    <= {W{1'b0}};
            s1_lane_r    <= {EW{1'b0}};
            start_last_r <= 1'b0;
        end else if (adv) begin
            s1_d_r       <= hd_d;
            s1_c_r       <= hd_c;
            s1_start_r   <= hd_start;
            s1_term_r    <= hd_term;
            s1_lane_r    <= hd_lane;
            start_last_r <= s1_start_r[W-1];
        end
    end

    // --------------------------------------------------------
    // end offset: back one byte, or five when the crc goes
    // --------------------------------------------------------
    wire [3:0] end_ofs;

    assign end_ofs = crc_strip_s_r ? `RXC_END_OFS_STRIP
                                   : `RXC_END_OFS_KEEP;

    // --------------------------------------------------------
    // per-word marking
    // --------------------------------------------------------
    wire [W-1:0]  sop_nxt;
    wire [W-1:0]  eop_nxt;
    wire [EW-1:0] empty_nxt;
    wire [DW-1:0] d_nxt;
    wire [CW-1:0] c_nxt;

    generate
        for (g = 0; g < W; g = g + 1) begin : g_mark
            wire       nx_term;
            wire [3:0] nx_lane;
            wire [3:0] own_lane;
            wire       own_hit;
            wire       nx_hit;
            wire [3:0] emp4;
            wire       prev_start;
            wire       drop_pre;

            // the word after this one: next in stage, or fifo head
            if (g == W - 1) begin : g_edge
                assign nx_term    = hd_term[0];
                assign nx_lane    = {1'b0, hd_lane[2:0]};
            end else begin : g_mid
                assign nx_term    = s1_term_r[g+1];
                assign nx_lane    = {1'b0, s1_lane_r[(g+1)*3 +: 3]};
            end

            // the word before this one: previous stage word at 0
            if (g == 0) begin : g_first
                assign prev_start = start_last_r;
            end else begin : g_rest
                assign prev_start = s1_start_r[g-1];
            end

            assign own_lane = {1'b0, s1_lane_r[g*3 +: 3]};

            // last kept byte falls in this word, from its own
            // terminate or from one early in the next word
            assign own_hit  = s1_term_r[g] && (own_lane >= end_ofs);
            assign nx_hit   = !s1_term_r[g] && nx_term &&
                              (nx_lane < end_ofs);
            assign eop_nxt[g] = adv && (own_hit || nx_hit);

            // empty bytes after the last kept byte; zero elsewhere
            assign emp4 = own_hit ? (`RXC_LAST_LANE + end_ofs - own_lane)
                        : nx_hit  ? (end_ofs - 4'h1 - nx_lane)
                        : 4'h0;
            assign empty_nxt[g*3 +: 3] = adv ? emp4[2:0] : 3'h0;

            // start marker: preamble word, or the word after it
            assign sop_nxt[g] = adv && (pre_pass_s_r ? s1_start_r[g]
                                                     : prev_start);

            // without pass-through the preamble word turns to idle
            assign drop_pre = !pre_pass_s_r && s1_start_r[g];
            assign d_nxt[g*64 +: 64] = drop_pre
                ? {`RXC_WORD_BYTES{`RXC_CH_IDLE}}
                : s1_d_r[g*64 +: 64];
            // in pass-through the start byte keeps its flag, preamble and sfd stay data; otherwise all eight flags are set
            assign c_nxt[g*8 +: 8] = drop_pre ? `RXC_CTRL_ALL
                                              : s1_c_r[g*8 +: 8];
        end
    endgenerate

    // --------------------------------------------------------
    // client output registers
    // --------------------------------------------------------
    // every output is a flop on the receive mac clock, which runs
    // at the client bus rate of the chosen width; the client
    // takes each word with no way to push back
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dout_d         <= {W{{`RXC_WORD_BYTES{`RXC_CH_IDLE}}}};
            dout_c         <= {W{`RXC_CTRL_ALL}};
            dout_sop       <= {W{1'b0}};
            dout_eop       <= {W{1'b0}};
            dout_eop_empty <= {EW{1'b0}};
            dout_valid     <= 1'b0;
        end else begin
            dout_sop       <= sop_nxt;
            dout_eop       <= eop_nxt;
            dout_eop_empty <= empty_nxt;
            dout_valid     <= adv;
            if (adv) begin
                dout_d     <= d_nxt;
                dout_c     <= c_nxt;
            end
        end
    end

endmodule

// ==== dv/rxc_stream_chk.sv ====
// assertion checker for the receive client word stream
`timescale 1ns/1ps
module rxc_stream_chk #(
    parameter W = 4
) (
    // clock and reset
    input wire            clock,
    input wire            resetn,
    // mode and stall pins
    input wire            preamble_pass,
    input wire            drain_hold,
    // client word bus
    input wire [W*64-1:0] dout_d,
    input wire [W*8-1:0]  dout_c,
    input wire [W-1:0]    dout_sop,
    input wire [W-1:0]    dout_eop,
    input wire [W*3-1:0]  dout_eop_empty,
    input wire            dout_valid
);
    logic [W-1:0]   l0c;
    logic [W-1:0]   emp_nz;
    logic [W*8-1:0] bad_c;
    // lane 0 flag per word, stray empty counts, odd control bytes
    for (genvar g = 0; g < W; g++) begin : g_w
        assign l0c[g] = dout_c[g*8];
        assign emp_nz[g] = !dout_eop[g] && (|dout_eop_empty[g*3+:3]);
    end
    for (genvar k = 0; k < W*8; k++) begin : g_b
        assign bad_c[k] = dout_c[k] && !(dout_d[k*8+:8] inside
                          {8'h07, 8'hfb, 8'hfd});
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_sop_onehot: assert property ($onehot0(dout_sop))
        else $error("start marker not one-hot");
    a_eop_onehot: assert property ($onehot0(dout_eop))
        else $error("end marker not one-hot");
    a_empty_zero: assert property (emp_nz == '0)
        else $error("empty count set on a non-end word");
    a_marks_valid: assert property (!dout_valid |-> !(|{dout_sop,
        dout_eop, dout_eop_empty})) else $error("marker without valid");
    a_sop_lane: assert property (dout_valid && (|dout_sop)
        |-> (|(dout_sop & l0c)) == preamble_pass)
        else $error("start word lane 0 flag wrong for mode");
    a_ctrl_bytes: assert property (bad_c == '0)
        else $error("control flag on a data byte");
    a_data_hold: assert property (!dout_valid |-> $stable(dout_d)
        && $stable(dout_c)) else $error("data moved without valid");
    a_valid_drain: assert property (
        dout_valid |-> !$past(drain_hold))
        else $error("output while draining held");
endmodule
bind rxc_stream rxc_stream_chk #(.W(W)) u_chk (.clock(clock),
    .resetn(resetn), .preamble_pass(preamble_pass),
    .drain_hold(drain_hold), .dout_d(dout_d), .dout_c(dout_c),
    .dout_sop(dout_sop), .dout_eop(dout_eop),
    .dout_eop_empty(dout_eop_empty), .dout_valid(dout_valid));

// ==== dv/rxc_sink.sv ====
// client model: takes every word group and measures frames
`timescale 1ns/1ps
module rxc_sink #(
    parameter W = 4
) (
    // clock and reset
    input wire            clock,
    input wire            resetn,
    // client word bus
    input wire [W*64-1:0] dout_d,
    input wire [W*8-1:0]  dout_c,
    input wire [W-1:0]    dout_sop,
    input wire [W-1:0]    dout_eop,
    input wire [W*3-1:0]  dout_eop_empty,
    input wire            dout_valid
);
    logic [W-1:0]   sop_w, eop_w;
    logic [W*3-1:0] empty_all;
    logic [63:0]    d0;
    logic [7:0]     c0;
    logic [15:0]    len, cnt_r;
    int             nvalid;
    bit             in_frm_r;
    // no stall possible: every valid group is taken at once;
    // the byte count runs in locals and is kept in cnt_r
    always @(posedge clock or negedge resetn) begin
        logic [15:0] cnt;
        bit          frm;
        cnt = cnt_r;
        frm = in_frm_r;
        if (!resetn) begin
            nvalid   <= 0;
            cnt_r    <= '0;
            in_frm_r <= 1'b0;
        end else if (dout_valid) begin
            nvalid <= nvalid + 1;
            if (|dout_sop) begin
                sop_w <= dout_sop;
                d0    <= dout_d[63:0];
                c0    <= dout_c[7:0];
            end
            for (int g = 0; g < W; g++) begin
                if (dout_sop[g]) begin
                    frm = 1'b1;
                    cnt = '0;
                end
                if (frm) cnt = cnt + 16'd8;
                if (frm && dout_eop[g]) begin
                    cnt = cnt - dout_eop_empty[g*3+:3];
                    len       <= cnt;
                    frm = 1'b0;
                    eop_w     <= dout_eop;
                    empty_all <= dout_eop_empty;
                end
            end
            cnt_r    <= cnt;
            in_frm_r <= frm;
        end
    end
endmodule

// ==== dv/rx_mac_client_word_stream_test.sv ====
// self-checking bench for the receive client word stream
`timescale 1ns/1ps
module rx_mac_client_word_stream_test;
    logic         clock = 0, resetn = 0;
    logic         preamble_pass = 0, crc_strip = 0, drain_hold = 0;
    logic         in_valid = 0;
    logic [255:0] in_d = '0;
    logic [31:0]  in_c = '0;
    wire          in_ready, dout_valid;
    wire [255:0]  dout_d;
    wire [31:0]   dout_c;
    wire [3:0]    dout_sop, dout_eop;
    wire [11:0]   dout_eop_empty;
    wire          in_ready2, dout_valid2;
    wire [127:0]  dout_d2;
    wire [15:0]   dout_c2;
    wire [1:0]    dout_sop2, dout_eop2;
    wire [5:0]    dout_eop_empty2;
    int           error_cnt = 0, checked = 0, cyc = 0, n;
    logic [255:0] fa_d, fb_d;
    logic [31:0]  fa_c, fb_c;

    rxc_stream #(.W(4)) dut (.clock(clock), .resetn(resetn),
        .preamble_pass(preamble_pass), .crc_strip(crc_strip),
        .drain_hold(drain_hold), .in_valid(in_valid),
        .in_ready(in_ready), .in_d(in_d), .in_c(in_c),
        .dout_d(dout_d), .dout_c(dout_c), .dout_sop(dout_sop),
        .dout_eop(dout_eop), .dout_eop_empty(dout_eop_empty),
        .dout_valid(dout_valid));
    rxc_sink #(.W(4)) sink (.clock(clock), .resetn(resetn),
        .dout_d(dout_d), .dout_c(dout_c), .dout_sop(dout_sop),
        .dout_eop(dout_eop), .dout_eop_empty(dout_eop_empty),
        .dout_valid(dout_valid));
    // two-word width fed with the low two words of each group
    rxc_stream #(.W(2)) dut2 (.clock(clock), .resetn(resetn),
        .preamble_pass(preamble_pass), .crc_strip(crc_strip),
        .drain_hold(drain_hold), .in_valid(in_valid),
        .in_ready(in_ready2), .in_d(in_d[127:0]), .in_c(in_c[15:0]),
        .dout_d(dout_d2), .dout_c(dout_c2), .dout_sop(dout_sop2),
        .dout_eop(dout_eop2), .dout_eop_empty(dout_eop_empty2),
        .dout_valid(dout_valid2));
    rxc_sink #(.W(2)) sink2 (.clock(clock), .resetn(resetn),
        .dout_d(dout_d2), .dout_c(dout_c2), .dout_sop(dout_sop2),
        .dout_eop(dout_eop2), .dout_eop_empty(dout_eop_empty2),
        .dout_valid(dout_valid2));

    always #50 clock = ~clock;
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // hold a group until it is taken, request stays up after
    task automatic push(input logic [255:0] d, input logic [31:0] c);
        @(negedge clock);
        in_valid = 1;
        in_d = d;
        in_c = c;
        while (!in_ready) @(negedge clock);
        @(posedge clock);
    endtask

    task automatic frame(input bit pass, input bit strip);
        @(negedge clock);
        in_valid = 0;
        preamble_pass = pass;
        crc_strip = strip;
        repeat (4) @(negedge clock);
        push(fa_d, fa_c);
        push(fb_d, fb_c);
        push({32{8'h07}}, 32'hffff_ffff);
        push({32{8'h07}}, 32'hffff_ffff);
        @(negedge clock);
        in_valid = 0;
        repeat (4) @(negedge clock);
    endtask

    task automatic t_reset();
        chk(dout_c, 32'hffff_ffff);
        chk(dout_d[63:0], 64'h0707_0707_0707_0707);
        chk(dout_valid, 1'b0);
        chk(dout_c2, 16'hffff);
        $display("test reset done");
    endtask

    task automatic t_pass_keep();
        frame(1, 0);
        chk(sink.sop_w, 4'h1);
        chk(sink.d0, fa_d[63:0]);
        chk(sink.c0, 8'h01);
        chk(sink.eop_w, 4'h2);
        chk(sink.empty_all, 12'h028);
        chk(sink.len, 43);
        chk(sink2.sop_w, 2'h1);
        chk(sink2.eop_w, 2'h2);
        chk(sink2.empty_all, 6'h28);
        chk(sink2.len, 27);
        $display("test pass keep done");
    endtask

    task automatic t_strip();
        frame(0, 1);
        chk(sink.sop_w, 4'h2);
        chk(sink.d0, 64'h0707_0707_0707_0707);
        chk(sink.c0, 8'hff);
        chk(sink.eop_w, 4'h1);
        chk(sink.empty_all, 12'h001);
        chk(sink.len, 31);
        chk(sink2.sop_w, 2'h2);
        chk(sink2.d0, 64'h0707_0707_0707_0707);
        chk(sink2.eop_w, 2'h1);
        chk(sink2.empty_all, 6'h01);
        chk(sink2.len, 15);
        $display("test strip done");
    endtask

    task automatic t_fill();
        int v0, v2, n2;
        v0 = sink.nvalid;
        v2 = sink2.nvalid;
        n = 0;
        n2 = 0;
        @(negedge clock);
        drain_hold = 1;
        in_valid = 1;
        in_d = {32{8'h07}};
        in_c = 32'hffff_ffff;
        repeat (8) begin
            @(negedge clock);
            if (in_ready === 1'b1) n++;
            if (in_ready2 === 1'b1) n2++;
        end
        chk(n, 3);
        chk(n2, 3);
        chk(sink.nvalid - v0, 0);
        chk(sink2.nvalid - v2, 0);
        in_valid = 0;
        drain_hold = 0;
        repeat (8) @(negedge clock);
        chk(sink.nvalid - v0, 4);
        chk(sink2.nvalid - v2, 4);
        chk(in_ready, 1'b1);
        chk(in_ready2, 1'b1);
        $display("test fill done");
    endtask

    initial begin
        fa_d = '0;
        fa_c = '0;
        fa_d[63:0] = 64'hd555_5555_5555_55fb;
        fa_c[0] = 1'b1;
        for (int i = 8; i < 32; i++) fa_d[i*8+:8] = i;
        fb_d = {32{8'h07}};
        fb_c = 32'hffff_f800;
        for (int i = 0; i < 11; i++) fb_d[i*8+:8] = 8'h40 + i;
        fb_d[95:88] = 8'hfd;
        repeat (12) @(negedge clock);
        t_reset();
        resetn = 1;
        t_pass_keep();
        t_strip();
        t_fill();
        tally_and_finish();
    end
endmodule
